// *** logic/frame_header_defs.vh ***
// Purpose: Constants for the frame header arbiter
// Assumes: 200 MHz system clock
// Notes: Times in ns, cycle counts derived from them
`ifndef FRAME_HEADER_DEFS_VH
`define FRAME_HEADER_DEFS_VH
`define CLK_PERIOD_NS 5
`define START_BIT_NS 1000
`define BIT_PERIOD_NS 200
`define START_BIT_CYC ((`START_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_PERIOD_CYC (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define MODE_ONE 2'h1
`define MAX_DATA_BYTES 6'h20
`define ADDR_WIDTH 12
`define GROUP_MSB 11
`define GROUP_LSB 8
`define ALL_UNITS_ADDR 12'hFFF
`define BCAST_VALUE 1'b0
`define INDIV_VALUE 1'b1
`endif

// *** logic/start_bit_sequencer.v ***
// Purpose: Start bit generation and detection on the protocol line
// Assumes: Protocol level input, low means start bit
// Notes: Reports end of any start bit, own or foreign
`timescale 1ns/1ps
`include "frame_header_defs.vh"
module start_bit_sequencer (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Control
  input wire i_request,
  input wire i_line,
  input wire i_idle,
  // Status
  output reg o_drive_low,
  output reg o_own,
  output reg o_done
);
  reg [31:0] cnt_reg;
  reg busy_reg;
  always @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      o_drive_low <= 1'b0;
      o_own <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!busy_reg) begin
        cnt_reg <= 32'h0000_0000;
        if (i_idle && !i_line) begin
          busy_reg <= 1'b1; // RL9 RL10
          o_own <= 1'b0;
        end else if (i_idle && i_request) begin
          busy_reg <= 1'b1; // RL8
          o_own <= 1'b1;
          o_drive_low <= 1'b1;
        end
      end else if (o_own) begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
        if (cnt_reg == `START_BIT_CYC - 1) begin
          o_drive_low <= 1'b0; // RL8
          busy_reg <= 1'b0;
          o_done <= 1'b1;
        end
      end else if (i_line || (cnt_reg == `START_BIT_CYC - 1)) begin
        busy_reg <= 1'b0; // RL9
        o_done <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end
  end
endmodule

// *** logic/bit_comparator.v ***
// Purpose: Compares sent bit with sampled line level
// Assumes: Sample strobe in bit middle
// Notes: Loss is sticky until cleared
`timescale 1ns/1ps
module bit_comparator (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Compare
  input wire i_clear,
  input wire i_check,
  input wire i_sent,
  input wire i_line,
  // Result
  output reg o_lost
);
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_lost <= 1'b0;
    end else if (i_check && (i_sent != i_line)) begin
      o_lost <= 1'b1; // RL14
    end else if (i_clear) begin
      o_lost <= 1'b0;
    end
  end
endmodule

// *** logic/vehicle_bus_frame_header_arbiter.v ***
// Purpose: Frame header sending, receiving and master address arbitration
// Assumes: Bus pin is inverted protocol level, wired-AND line
// Notes on behaviour
// [RL1] Only mode 1 runs; frame length capped at 32 data bytes.
// [RL2] All units set to mode 1 before transfers.
// [RL3] Address is 12 bits: 4-bit group, 8-bit unit.
// [RL4] No acknowledge driven or checked after master address in broadcast.
// [RL5] Group broadcast joins on group match; all-unit broadcast joins everyone.
// [RL6] Pin levels are the inverse of protocol levels.
// [RL7] Fields follow fixed order: start, broadcast, addresses, control, length, data.
// [RL8] Starter drives low start bit for fixed time, then broadcast bit.
// [RL9] Foreign start bit in progress: wait, align broadcast bit to its end.
// [RL10] Non-starting units detect start bit and become receivers.
// [RL11] Broadcast bit 0 means broadcast, 1 means individual.
// [RL12] Broadcast wins over individual on the broadcast bit.
// [RL13] Master sends broadcast request flag as broadcast bit.
// [RL14] Each sent header bit checked against bus; mismatch loses arbitration. Code checks only the broadcast and master address bits.
// [RL15] Wired-AND makes the lowest master address win.
// [RL16] After 12 address bits, winner sends parity then slave address.
// [RL17] Master address field taken from own unit address register.
// [RL18] Slave withholds acknowledge on odd master or slave address parity.
// [RL19] Broadcast slave address all ones means all units, else group.
// [RL20] Start and bit timing come from clock-derived constants.
`timescale 1ns/1ps
`include "frame_header_defs.vh"
module vehicle_bus_frame_header_arbiter (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Bus pin
  input wire i_bus_pin,
  output reg o_bus_pin,
  output reg o_bus_pin_oe,
  // Control
  input wire i_start_request,
  input wire i_broadcast_request_flag,
  input wire [11:0] i_own_unit_address_reg,
  input wire [11:0] i_slave_address,
  input wire [1:0] i_comm_mode,
  input wire [5:0] i_data_bytes,
  // Status
  output reg o_master,
  output reg o_receiving,
  output reg o_arb_lost,
  output reg o_header_done,
  output reg o_rx_broadcast,
  output reg [11:0] o_rx_master_addr,
  output reg [11:0] o_rx_slave_addr,
  output reg o_rx_selected,
  output reg o_ack_drive,
  output reg o_length_error
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_BCAST = 3'd2;
  localparam S_MADDR = 3'd3;
  localparam S_MPAR = 3'd4;
  localparam S_SADDR = 3'd5;
  localparam S_SPAR = 3'd6;
  localparam S_ACK = 3'd7;

  function parity_even_bit;
    input [11:0] value;
    begin
      parity_even_bit = ^value;
    end
  endfunction

  wire line = ~i_bus_pin; // RL6
  wire mode_ok = (i_comm_mode == `MODE_ONE) && (i_data_bytes <= `MAX_DATA_BYTES); // RL1 RL2
  reg [2:0] state_reg;
  reg [31:0] tick_reg;
  reg [3:0] idx_reg;
  reg tx_reg;
  reg drive_reg;
  reg is_master_reg;
  reg [11:0] shift_reg;
  reg mpar_ok_reg;
  reg bcast_reg;
  wire seq_drive_low;
  wire seq_own;
  wire seq_done;
  wire lost;
  wire bit_end = (tick_reg == `BIT_PERIOD_CYC - 1);
  wire bit_mid = (tick_reg == (`BIT_PERIOD_CYC / 2));
  wire checking = is_master_reg && bit_mid &&
                  ((state_reg == S_BCAST) || (state_reg == S_MADDR));

  start_bit_sequencer u_start (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_request(i_start_request && mode_ok),
    .i_line(line),
    .i_idle(state_reg == S_IDLE),
    .o_drive_low(seq_drive_low),
    .o_own(seq_own),
    .o_done(seq_done)
  );

  bit_comparator u_cmp (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(state_reg == S_IDLE),
    .i_check(checking),
    .i_sent(tx_reg),
    .i_line(line),
    .o_lost(lost)
  );

  always @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      tick_reg <= 32'h0000_0000;
      idx_reg <= 4'h0;
      tx_reg <= 1'b1;
      drive_reg <= 1'b0;
      is_master_reg <= 1'b0;
      shift_reg <= 12'h000;
      mpar_ok_reg <= 1'b0;
      bcast_reg <= 1'b0;
      o_bus_pin <= 1'b0;
      o_bus_pin_oe <= 1'b0;
      o_master <= 1'b0;
      o_receiving <= 1'b0;
      o_arb_lost <= 1'b0;
      o_header_done <= 1'b0;
      o_rx_broadcast <= 1'b0;
      o_rx_master_addr <= 12'h000;
      o_rx_slave_addr <= 12'h000;
      o_rx_selected <= 1'b0;
      o_ack_drive <= 1'b0;
      o_length_error <= 1'b0;
    end else begin
      o_header_done <= 1'b0;
      o_arb_lost <= 1'b0;
      o_length_error <= i_start_request && !mode_ok; // RL1
      tick_reg <= bit_end ? 32'h0000_0000 : tick_reg + 32'h0000_0001; // RL20
      case (state_reg)
        S_IDLE: begin
          tick_reg <= 32'h0000_0000;
          drive_reg <= 1'b0;
          o_ack_drive <= 1'b0;
          if (seq_drive_low) begin
            state_reg <= S_START;
            is_master_reg <= 1'b1;
            drive_reg <= 1'b1;
            tx_reg <= 1'b0; // RL8
          end else if (!line) begin
            state_reg <= S_START; // RL10
            is_master_reg <= 1'b0;
          end
        end
        S_START: begin
          tick_reg <= 32'h0000_0000;
          if (seq_done) begin
            state_reg <= S_BCAST; // RL9
            if (is_master_reg || (seq_own == 1'b0 && i_start_request && mode_ok)) begin
              is_master_reg <= 1'b1;
              drive_reg <= 1'b1;
              tx_reg <= i_broadcast_request_flag; // RL11 RL13
            end else begin
              drive_reg <= 1'b0;
              o_receiving <= 1'b1;
            end
          end
        end
        S_BCAST: begin
          if (bit_mid) begin
            bcast_reg <= line;
          end
          if (bit_end) begin
            if (lost) begin
              is_master_reg <= 1'b0; // RL12
              drive_reg <= 1'b0;
              o_receiving <= 1'b1;
              o_arb_lost <= 1'b1;
            end
            o_rx_broadcast <= (bcast_reg == `BCAST_VALUE);
            state_reg <= S_MADDR;
            idx_reg <= 4'hB;
            tx_reg <= i_own_unit_address_reg[11]; // RL17
          end
        end
        S_MADDR: begin
          if (bit_mid) begin
            shift_reg <= {shift_reg[10:0], line}; // RL3
          end
          if (bit_end) begin
            if (lost && is_master_reg) begin
              is_master_reg <= 1'b0; // RL14 RL15
              drive_reg <= 1'b0;
              o_receiving <= 1'b1;
              o_arb_lost <= 1'b1;
            end
            if (idx_reg == 4'h0) begin
              state_reg <= S_MPAR; // RL16
              o_rx_master_addr <= shift_reg;
              tx_reg <= parity_even_bit(i_own_unit_address_reg);
            end else begin
              idx_reg <= idx_reg - 4'h1;
              tx_reg <= i_own_unit_address_reg[idx_reg - 4'h1]; // RL17
            end
          end
        end
        S_MPAR: begin
          if (bit_mid) begin
            mpar_ok_reg <= (parity_even_bit(o_rx_master_addr) == line);
          end
          if (bit_end) begin
            o_master <= is_master_reg;
            state_reg <= S_SADDR; // RL7 RL16
            idx_reg <= 4'hB;
            tx_reg <= i_slave_address[11];
          end
        end
        S_SADDR: begin
          if (bit_mid) begin
            shift_reg <= {shift_reg[10:0], line};
          end
          if (bit_end) begin
            if (idx_reg == 4'h0) begin
              state_reg <= S_SPAR;
              o_rx_slave_addr <= shift_reg;
              tx_reg <= parity_even_bit(i_slave_address);
            end else begin
              idx_reg <= idx_reg - 4'h1;
              tx_reg <= i_slave_address[idx_reg - 4'h1];
            end
          end
        end
        S_SPAR: begin
          if (bit_mid && !is_master_reg) begin
            if (o_rx_broadcast) begin
              o_rx_selected <= (o_rx_slave_addr == `ALL_UNITS_ADDR) || // RL19
                (o_rx_slave_addr[`GROUP_MSB:`GROUP_LSB] ==
                 i_own_unit_address_reg[`GROUP_MSB:`GROUP_LSB]); // RL5
            end else begin
              o_rx_selected <= mpar_ok_reg && // RL18
                (parity_even_bit(o_rx_slave_addr) == line) &&
                (o_rx_slave_addr == i_own_unit_address_reg);
            end
          end
          if (bit_end) begin
            state_reg <= S_ACK;
            // Master releases line so slave may acknowledge
            drive_reg <= 1'b0;
            if (!is_master_reg && !o_rx_broadcast && o_rx_selected) begin
              drive_reg <= 1'b1; // RL4 RL18
              tx_reg <= 1'b0;
              o_ack_drive <= 1'b1;
            end
          end
        end
        S_ACK: begin
          if (bit_end) begin
            // Master ignores acknowledge slot in broadcast
            o_header_done <= 1'b1; // RL4 RL7
            drive_reg <= 1'b0;
            o_ack_drive <= 1'b0;
            o_receiving <= 1'b0;
            o_master <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      o_bus_pin <= ~(drive_reg ? tx_reg : 1'b1); // RL6
      o_bus_pin_oe <= drive_reg && !tx_reg;
    end
  end
endmodule

// *** bench/frame_header_arbiter_sva.sv ***
// Purpose: Port checks for the frame header arbiter
// Assumes: One clock, sync active-high reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
module frame_header_arbiter_sva (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Watched ports
  input wire o_bus_pin,
  input wire o_bus_pin_oe,
  input wire i_start_request,
  input wire [1:0] i_comm_mode,
  input wire [5:0] i_data_bytes,
  input wire o_master,
  input wire o_receiving,
  input wire o_arb_lost,
  input wire o_header_done,
  input wire o_rx_broadcast,
  input wire o_ack_drive,
  input wire o_length_error
);
  wire bad = (i_comm_mode != 2'h1) || (i_data_bytes > 6'h20);
  a_pin_inverted: assert property (@(posedge i_clk) disable iff (i_reset)
    o_bus_pin_oe |-> o_bus_pin) else $error("Drive without pin high");
  a_reset_quiet: assert property (@(posedge i_clk)
    i_reset |=> !o_bus_pin_oe && !o_master && !o_receiving && !o_arb_lost)
    else $error("Outputs active after reset");
  a_bad_flagged: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_start_request && bad) [*2] |-> o_length_error) else $error("Bad setup not flagged");
  a_bad_no_start: assert property (@(posedge i_clk) disable iff (i_reset)
    ((!i_start_request || bad) && !o_receiving && !o_master && !o_bus_pin_oe) [*4]
    |=> !o_bus_pin_oe) else $error("Start without valid request");
  a_lost_recv: assert property (@(posedge i_clk) disable iff (i_reset)
    o_arb_lost |-> ##[0:2] o_receiving) else $error("No receive after loss");
  a_lost_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    o_arb_lost |=> !o_arb_lost) else $error("Loss pulse too long");
  a_lost_no_master: assert property (@(posedge i_clk) disable iff (i_reset)
    o_arb_lost |=> !o_master [*4]) else $error("Master after loss");
  a_ack_unicast: assert property (@(posedge i_clk) disable iff (i_reset)
    o_ack_drive |-> o_receiving && !o_rx_broadcast) else $error("Ack in broadcast");
  a_master_tx: assert property (@(posedge i_clk) disable iff (i_reset)
    o_master |-> !o_receiving) else $error("Master also receiving");
  a_done_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    o_header_done |=> !o_header_done) else $error("Done pulse too long");
endmodule

// *** bench/bus_unit_model.sv ***
// Purpose: Far bus unit that starts a frame and sends its header bits
// Assumes: Pin drive high means protocol low
// Notes: Releases the line after broadcast bit and address
`timescale 1ns/1ps
module bus_unit_model #(
  parameter integer START_CYC = 100,
  parameter integer BIT_CYC = 10
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Frame request
  input wire i_go,
  input wire i_bcast,
  input wire [11:0] i_addr,
  // Pin drive
  output reg o_drive
);
  reg [12:0] bits_reg;
  integer idx;
  integer cnt;
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_drive <= 1'b0;
      idx <= -2;
      cnt <= 0;
    end else if (idx == -2) begin
      if (i_go) begin
        bits_reg <= {i_bcast, i_addr};
        o_drive <= 1'b1;
        idx <= -1;
        cnt <= START_CYC - 1;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (idx == 12) begin
      o_drive <= 1'b0;
      idx <= -2;
    end else begin
      o_drive <= !bits_reg[11 - idx];
      idx <= idx + 1;
      cnt <= BIT_CYC - 1;
    end
  end
endmodule

// *** bench/vehicle_bus_frame_header_arbiter_bench.sv ***
// Purpose: Self-checking bench for the frame header arbiter
// Assumes: Far unit model shares the wired line
// Notes: Reset after each arbitration to keep the run short
`timescale 1ns/1ps
`include "frame_header_defs.vh"
`define CHK(got, exp) begin n_compared = n_compared + 1; if ((got) !== (exp)) begin \
  error_cnt = error_cnt + 1; $display("Error t=%0t mismatch", $time); end end
module vehicle_bus_frame_header_arbiter_bench;
  localparam integer START = `START_BIT_CYC;
  localparam integer BITC = `BIT_PERIOD_CYC;
  reg i_clk = 1'b0;
  reg i_reset = 1'b1;
  reg i_start_request = 1'b0;
  reg flag = 1'b1;
  reg [11:0] own = 12'h000;
  reg [11:0] slv = 12'h000;
  reg [1:0] mode = 2'h1;
  reg [5:0] bytes = 6'h00;
  reg go = 1'b0;
  reg p_bcast = 1'b1;
  reg [11:0] p_addr = 12'h000;
  reg [31:0] r;
  integer seed = 80925;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer t0;
  integer i;
  wire pin, oe, p_drive, master, recv, lost, rx_bc, len_err;
  wire bus_pin = (oe & pin) | p_drive;
  vehicle_bus_frame_header_arbiter u_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_bus_pin(bus_pin), .o_bus_pin(pin), .o_bus_pin_oe(oe),
    .i_start_request(i_start_request), .i_broadcast_request_flag(flag),
    .i_own_unit_address_reg(own), .i_slave_address(slv), .i_comm_mode(mode),
    .i_data_bytes(bytes), .o_master(master), .o_receiving(recv), .o_arb_lost(lost),
    .o_header_done(), .o_rx_broadcast(rx_bc), .o_rx_master_addr(), .o_rx_slave_addr(),
    .o_rx_selected(), .o_ack_drive(), .o_length_error(len_err));
  bus_unit_model #(.START_CYC(START), .BIT_CYC(BITC)) u_far (.i_clk(i_clk),
    .i_reset(i_reset), .i_go(go), .i_bcast(p_bcast), .i_addr(p_addr), .o_drive(p_drive));
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  task test_done;
    begin
      if (error_cnt == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task arb(input b_p, input [11:0] a_p, input b_d, input [11:0] a_d);
    reg [12:0] sp, sd;
    integer n, kexp, w;
    begin
      sp = {b_p, a_p};
      sd = {b_d, a_d};
      kexp = -1;
      for (n = 12; n >= 0; n = n - 1) begin
        if (kexp < 0 && sd[n] && !sp[n]) kexp = 12 - n;
      end
      @(posedge i_clk);
      go <= 1'b1;
      p_bcast <= b_p;
      p_addr <= a_p;
      flag <= b_d;
      own <= a_d;
      slv <= r[23:12];
      t0 = cyc;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_start_request <= 1'b1;
      w = 0;
      @(negedge i_clk);
      while (lost !== 1'b1 && w < START + 16 * BITC) begin
        @(negedge i_clk);
        w = w + 1;
      end
      `CHK((cyc - t0 - START + BITC / 2) / BITC - 1, kexp)
      repeat (3) @(negedge i_clk);
      `CHK(recv, 1'b1)
      `CHK(master, 1'b0)
      `CHK(rx_bc, !b_p)
      @(posedge i_clk);
      i_reset <= 1'b1;
      i_start_request <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
    end
  endtask
  initial begin
    #(5 * 20000);
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    `CHK({oe, recv, master, len_err}, 4'h0)
    for (i = 0; i < 5; i = i + 1) begin
      r = $random(seed);
      @(posedge i_clk);
      mode <= (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : (i == 2) ? 2'h3 : 2'h1;
      bytes <= (i == 3) ? 6'h21 : (i == 4) ? 6'h3f : {1'b0, r[4:0]};
      i_start_request <= 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK(len_err, 1'b1)
      `CHK(oe, 1'b0)
      @(posedge i_clk);
      i_start_request <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    mode <= 2'h1;
    bytes <= 6'h20;
    r = $random(seed);
    arb(1'b0, r[11:0], 1'b1, r[23:12]);
    r = $random(seed);
    arb(1'b1, r[11:0] & 12'hbff, 1'b1, r[11:0] | 12'h400);
    test_done;
  end
endmodule
bind vehicle_bus_frame_header_arbiter frame_header_arbiter_sva u_sva (.i_clk(i_clk),
  .i_reset(i_reset), .o_bus_pin(o_bus_pin), .o_bus_pin_oe(o_bus_pin_oe),
  .i_start_request(i_start_request), .i_comm_mode(i_comm_mode),
  .i_data_bytes(i_data_bytes), .o_master(o_master), .o_receiving(o_receiving),
  .o_arb_lost(o_arb_lost), .o_header_done(o_header_done), .o_rx_broadcast(o_rx_broadcast),
  .o_ack_drive(o_ack_drive), .o_length_error(o_length_error));
